// *** core/mpfc_pkg.sv ***
package mpfc_pkg;

  // ==========================================================
  // register map (word index, byte address is four times it)
  // ==========================================================
  localparam logic [7:0]  FLOW_IDX     = 8'h08;
  localparam logic [7:0]  AFC_IDX      = 8'h10;
  localparam logic [9:0]  FLOW_ADDR    = {FLOW_IDX, 2'b00};
  localparam logic [9:0]  AFC_ADDR     = {AFC_IDX, 2'b00};
  localparam logic [31:0] FLOW_RST     = 32'h0000_0000;
  localparam logic [31:0] AFC_RST      = 32'h0000_0000;

  // pause_flow_control fields
  localparam int PT_LSB   = 16;
  localparam int FWD_BIT  = 2;
  localparam int FLOW_CTRL_ENABLE_BIT = 1;
  localparam int BUSY_BIT = 0;

  // auto_flow_config_reg fields
  localparam int AFC_SEND_BIT = 0;
  localparam int AFC_BP_BIT   = 1;
  localparam int AFC_FDX_BIT  = 2;
  localparam int AFC_TXEN_BIT = 3;
  localparam int AFC_SPD_BIT  = 4;
  localparam int AFC_USED     = 5;

  // ==========================================================
  // pause frame layout
  // ==========================================================
  localparam logic [5:0] FRM_LAST   = 6'h3B;
  localparam logic [5:0] SA_FIRST   = 6'h06;
  localparam logic [5:0] TYPE_HI    = 6'h0C;
  localparam logic [5:0] TYPE_LO    = 6'h0D;
  localparam logic [5:0] OPC_HI     = 6'h0E;
  localparam logic [5:0] OPC_LO     = 6'h0F;
  localparam logic [5:0] PT_HI      = 6'h10;
  localparam logic [5:0] PT_LO      = 6'h11;
  localparam logic [5:0] HDR_LEN    = 6'h12;
  localparam logic [47:0] PAUSE_DA  = 48'h0180_C200_0001;
  localparam logic [15:0] CTRL_TYPE = 16'h8808;
  localparam logic [15:0] PAUSE_OPC = 16'h0001;

  // ==========================================================
  // timing
  // ==========================================================
  localparam int CLK_NS       = 50;
  localparam int QUANTUM_BITS = 512;
  localparam int BIT_NS_100   = 10;
  localparam int BIT_NS_10    = 100;
  localparam logic [10:0] QCYC_100 = 11'((QUANTUM_BITS * BIT_NS_100 + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] QCYC_10  = 11'((QUANTUM_BITS * BIT_NS_10 + CLK_NS - 1) / CLK_NS);

  // ==========================================================
  // carriers
  // ==========================================================
  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       eof;
    logic       good;
    logic [7:0] data;
  } mpfc_rx_beat_t;

  typedef struct packed {
    logic valid;
    logic is_pause;
    logic filter_pass;
  } mpfc_rx_stat_t;

  typedef enum logic {TX_IDLE, TX_SEND} mpfc_tx_st_t;

endpackage

// *** core/mpfc_top.sv ***
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
// Overview of operation
// - pause time field copied into sent frames
// - other frame fields follow 802.3x layout
// - full duplex busy while pause frame sends
// - half duplex busy while back pressure asserted
// - busy clears after pause frame completes
// - no pause or back pressure when tx disabled
// - valid received pause stops transmitter for time
// - enable clear means no decode, no pause
// - half duplex enable gates back pressure
// - forward bit passes pause, else filter cleared
// - all received frame data forwarded
// - promiscuous filtering overrides forward bit
// - pause requests come through config register
module mpfc_top (
  // apb slave
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // mac context
  input  wire logic [47:0]            station_addr,
  input  wire logic                   promisc,
  input  wire logic                   addr_filter_pass,
  // pause frame byte stream towards the transmitter
  output logic                        tx_valid,
  output logic      [7:0]             tx_data,
  output logic                        tx_last,
  input  wire logic                   tx_ready,
  // transmitter control
  output logic                        tx_hold,
  output logic                        backpressure,
  // receive side
  input  wire mpfc_pkg::mpfc_rx_beat_t rx_in,
  output mpfc_pkg::mpfc_rx_beat_t      rx_fwd,
  output mpfc_pkg::mpfc_rx_stat_t      rx_stat
);

  // ==========================================================
  // registers and decode
  // ==========================================================
  localparam int AFC_W = mpfc_pkg::AFC_USED;
  logic [31:0] flow_q;
  logic [AFC_W-1:0] afc_q;
  logic [31:0] prdata_q;
  logic        hit_flow;
  logic        hit_afc;
  logic        wr_en;
  logic        send_req;
  logic        full_duplex;
  logic        tx_enable;
  logic        fc_enable;
  logic        flow_ctrl_busy;
  mpfc_pkg::mpfc_tx_st_t tx_st_q;
  logic [5:0]  tx_idx_q;
  logic        tx_hs;
  logic        tx_start;

  assign hit_flow    = paddr[9:0] == mpfc_pkg::FLOW_ADDR && paddr[31:10] == '0;
  assign hit_afc     = paddr[9:0] == mpfc_pkg::AFC_ADDR && paddr[31:10] == '0;
  assign wr_en       = psel && penable && pwrite;
  assign full_duplex = afc_q[mpfc_pkg::AFC_FDX_BIT];
  assign tx_enable   = afc_q[mpfc_pkg::AFC_TXEN_BIT];
  assign fc_enable   = flow_q[mpfc_pkg::FLOW_CTRL_ENABLE_BIT];

  // zero wait state answer, error on unmapped address
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(hit_flow || hit_afc);
  assign prdata  = prdata_q;

  // flow register; busy position is read only and never stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flow_q <= mpfc_pkg::FLOW_RST;
    else if (wr_en && hit_flow)
      flow_q <= {pwdata[31:mpfc_pkg::PT_LSB], 13'h0000, pwdata[mpfc_pkg::FWD_BIT:mpfc_pkg::FLOW_CTRL_ENABLE_BIT], 1'b0};
  end

  // config register; send bit self clears once a frame starts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      afc_q <= AFC_W'(mpfc_pkg::AFC_RST);
    else if (wr_en && hit_afc)
      afc_q <= pwdata[AFC_W-1:0];
    else if (tx_start)
      afc_q[mpfc_pkg::AFC_SEND_BIT] <= 1'b0;
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable)
      prdata_q <= hit_flow ? {flow_q[31:1], flow_ctrl_busy} :
                  hit_afc  ? {27'h0000000, afc_q} : 32'h0000_0000;
  end

  // ==========================================================
  // pause frame transmit
  // ==========================================================
  function automatic logic [7:0] frame_byte(input logic [5:0] i, input logic [47:0] sa, input logic [15:0] pt);
    logic [5:0] s;
    s = i - mpfc_pkg::SA_FIRST;
    if (i < mpfc_pkg::SA_FIRST)
      frame_byte = mpfc_pkg::PAUSE_DA[8'(47 - 8 * i) -: 8];
    else if (i < mpfc_pkg::TYPE_HI)
      frame_byte = sa[8'(47 - 8 * s) -: 8];
    else if (i == mpfc_pkg::TYPE_HI)
      frame_byte = mpfc_pkg::CTRL_TYPE[15:8];
    else if (i == mpfc_pkg::TYPE_LO)
      frame_byte = mpfc_pkg::CTRL_TYPE[7:0];
    else if (i == mpfc_pkg::OPC_HI)
      frame_byte = mpfc_pkg::PAUSE_OPC[15:8];
    else if (i == mpfc_pkg::OPC_LO)
      frame_byte = mpfc_pkg::PAUSE_OPC[7:0];
    else if (i == mpfc_pkg::PT_HI)
      frame_byte = pt[15:8];
    else if (i == mpfc_pkg::PT_LO)
      frame_byte = pt[7:0];
    else
      frame_byte = 8'h00;
  endfunction

  assign send_req = afc_q[mpfc_pkg::AFC_SEND_BIT];
  assign tx_start = tx_st_q == mpfc_pkg::TX_IDLE && send_req && full_duplex && tx_enable;
  assign tx_valid = tx_st_q == mpfc_pkg::TX_SEND;
  assign tx_hs    = tx_valid && tx_ready;
  assign tx_last  = tx_valid && tx_idx_q == mpfc_pkg::FRM_LAST;

  // frame sequencer; bytes carry the programmed pause time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_st_q  <= mpfc_pkg::TX_IDLE;
      tx_idx_q <= 6'h00;
      tx_data  <= 8'h00;
    end
    else
    begin
      unique case (tx_st_q)
        mpfc_pkg::TX_IDLE:
        begin
          if (tx_start)
          begin
            tx_st_q  <= mpfc_pkg::TX_SEND;
            tx_idx_q <= 6'h00;
            tx_data  <= frame_byte(6'h00, station_addr, flow_q[31:16]);
          end
        end
        mpfc_pkg::TX_SEND:
        begin
          if (tx_hs && tx_last)
            tx_st_q <= mpfc_pkg::TX_IDLE;
          else if (tx_hs)
          begin
            tx_idx_q <= tx_idx_q + 6'h01;
            tx_data  <= frame_byte(tx_idx_q + 6'h01, station_addr, flow_q[31:16]);
          end
        end
      endcase
    end
  end

  // ==========================================================
  // half duplex back pressure and busy
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      backpressure <= 1'b0;
    else
      backpressure <= !full_duplex && fc_enable && tx_enable && afc_q[mpfc_pkg::AFC_BP_BIT];
  end

  assign flow_ctrl_busy = tx_valid || backpressure;

  // ==========================================================
  // receive decode
  // ==========================================================
  logic [5:0]  rx_idx_q;
  logic [5:0]  rx_cur;
  logic        match_q;
  logic        byte_ok;
  logic [15:0] pt_rx_q;
  logic        rx_pause;
  logic [15:0] pause_cnt_q;
  logic [10:0] quanta_q;
  logic [10:0] qcyc;

  assign rx_cur  = rx_in.sof ? 6'h00 : rx_idx_q;
  assign byte_ok = rx_cur >= mpfc_pkg::TYPE_HI || rx_cur < mpfc_pkg::SA_FIRST ?
                   frame_byte(rx_cur, 48'h0, {8'h00, rx_in.data}) == rx_in.data || rx_cur >= mpfc_pkg::PT_HI : 1'b1;
  // pause detected only while enabled and in full duplex
  assign rx_pause = rx_in.valid && rx_in.eof && rx_in.good && fc_enable && full_duplex && match_q && byte_ok
                    && rx_cur >= mpfc_pkg::HDR_LEN;

  // byte index and header match tracking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_idx_q <= 6'h00;
      match_q  <= 1'b0;
      pt_rx_q  <= 16'h0000;
    end
    else if (rx_in.valid)
    begin
      rx_idx_q <= rx_cur == 6'h3F ? rx_cur : rx_cur + 6'h01;
      match_q  <= (rx_in.sof || match_q) && byte_ok;
      if (rx_cur == mpfc_pkg::PT_HI)
        pt_rx_q[15:8] <= rx_in.data;
      if (rx_cur == mpfc_pkg::PT_LO)
        pt_rx_q[7:0] <= rx_in.data;
    end
  end

  // data passes through untouched, status at frame end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_fwd  <= '0;
      rx_stat <= '0;
    end
    else
    begin
      rx_fwd            <= rx_in;
      rx_stat.valid     <= rx_in.valid && rx_in.eof;
      rx_stat.is_pause  <= rx_pause;
      rx_stat.filter_pass <= rx_pause ? (flow_q[mpfc_pkg::FWD_BIT] || promisc)
                                      : addr_filter_pass;
    end
  end

  // ==========================================================
  // pause timer in slot quanta
  // ==========================================================
  assign qcyc    = afc_q[mpfc_pkg::AFC_SPD_BIT] ? mpfc_pkg::QCYC_100 : mpfc_pkg::QCYC_10;
  assign tx_hold = pause_cnt_q != 16'h0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pause_cnt_q <= 16'h0000;
      quanta_q    <= 11'h000;
    end
    else if (rx_pause)
    begin
      pause_cnt_q <= pt_rx_q;
      quanta_q    <= qcyc;
    end
    else if (!fc_enable)
      pause_cnt_q <= 16'h0000;
    else if (tx_hold && quanta_q <= 11'h001)
    begin
      pause_cnt_q <= pause_cnt_q - 16'h0001;
      quanta_q    <= qcyc;
    end
    else if (tx_hold)
      quanta_q <= quanta_q - 11'h001;
  end

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_busy_fd;
    psel && !penable && hit_flow && tx_valid |=> prdata[mpfc_pkg::BUSY_BIT];
  endproperty
  property p_busy_hd;
    psel && !penable && hit_flow && backpressure |=> prdata[mpfc_pkg::BUSY_BIT];
  endproperty
  property p_busy_clr;
    tx_hs && tx_last && full_duplex && !backpressure |=> !flow_ctrl_busy || !full_duplex;
  endproperty
  property p_pt_field;
    tx_valid && tx_idx_q == mpfc_pkg::PT_HI |-> tx_data == flow_q[31:24];
  endproperty
  property p_type_field;
    tx_valid && tx_idx_q == mpfc_pkg::TYPE_HI |-> tx_data == mpfc_pkg::CTRL_TYPE[15:8];
  endproperty
  property p_tx_dis;
    $rose(tx_valid) |-> $past(tx_enable);
  endproperty
  property p_pause_load;
    rx_pause |=> pause_cnt_q == $past(pt_rx_q);
  endproperty
  property p_no_decode;
    !fc_enable |=> !rx_stat.is_pause;
  endproperty
  property p_filter;
    rx_stat.is_pause && !$past(flow_q[mpfc_pkg::FWD_BIT]) && !$past(promisc) |-> !rx_stat.filter_pass;
  endproperty
  property p_fwd;
    rx_in.valid |=> rx_fwd.valid && rx_fwd.data == $past(rx_in.data);
  endproperty
  property p_quanta;
    tx_hold && fc_enable && !rx_pause && quanta_q == 11'h001 |=> pause_cnt_q == $past(pause_cnt_q) - 16'h0001;
  endproperty

  a_busy_fd:    assert property (p_busy_fd) else $error("busy dropped during pause frame");
  a_busy_hd:    assert property (p_busy_hd) else $error("busy low during back pressure");
  a_busy_clr:   assert property (p_busy_clr) else $error("busy stuck after frame");
  a_pt_field:   assert property (p_pt_field) else $error("pause time byte wrong");
  a_type_field: assert property (p_type_field) else $error("type byte wrong");
  a_tx_dis:     assert property (p_tx_dis) else $error("frame sent with tx disabled");
  a_pause_load: assert property (p_pause_load) else $error("pause time not loaded");
  a_no_decode:  assert property (p_no_decode) else $error("decode while disabled");
  a_filter:     assert property (p_filter) else $error("filter bit not cleared");
  a_fwd:        assert property (p_fwd) else $error("rx data not forwarded");
  a_quanta:     assert property (p_quanta) else $error("quantum not counted");

  c_frame: cover property (tx_hs && tx_last);
  c_pause: cover property (rx_pause);
  c_bp:    cover property ($rose(backpressure));
  c_done:  cover property ($fell(tx_hold));

endmodule

// *** tb/mac_pause_flow_control_tb.sv ***
`timescale 1ns/100ps
// ==========================================================
// flow control block bench
// ==========================================================
module mac_pause_flow_control_tb;
  logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0]             paddr, pwdata, prdata, rng, rd, fl;
  logic [47:0]             station_addr;
  logic                    promisc, addr_filter_pass, tx_valid, tx_last, tx_ready, tx_hold, backpressure, er;
  logic [7:0]              tx_data;
  logic [7:0]              f[$];
  mpfc_pkg::mpfc_rx_beat_t rx_in, rx_fwd, prev_in;
  mpfc_pkg::mpfc_rx_stat_t rx_stat;
  mpfc_pkg::mpfc_rx_stat_t stat_q[$];
  int                      mismatches, cmp_count, hold_cnt, e, q;
  logic [15:0]             t;
  logic                    fwd, prm, spd, ok, en;

  mpfc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .station_addr(station_addr), .promisc(promisc), .addr_filter_pass(addr_filter_pass),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .tx_hold(tx_hold),
    .backpressure(backpressure), .rx_in(rx_in), .rx_fwd(rx_fwd), .rx_stat(rx_stat));
  mpfc_station station (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .rx_in(rx_in));

  // clock
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  // watch pause hold, receive status and forwarded beats
  always @(posedge pclk)
  begin
    if (tx_hold === 1'b1)
      hold_cnt <= hold_cnt + 1;
    if (rx_stat.valid === 1'b1)
      stat_q.push_back(rx_stat);
    if (presetn === 1'b1 && prev_in.valid)
      chk({20'h0, rx_fwd}, {20'h0, prev_in});
    prev_in <= rx_in;
  end

  // stimulus generator
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, waiting for pready
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {22'h0, a};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // poll busy clear, then write with busy bit zero
  task automatic wr_flow(input logic [31:0] d);
    do
      apb(1'b0, mpfc_pkg::FLOW_ADDR, 32'h0);
    while (rd[0] !== 1'b0);
    apb(1'b1, mpfc_pkg::FLOW_ADDR, {d[31:1], 1'b0});
  endtask

  // pause frame: control address, source, type, opcode, time, pad
  task automatic build(input logic [47:0] sa, input logic [15:0] tm);
    f = '{8'h01, 8'h80, 8'hC2, 8'h00, 8'h00, 8'h01};
    for (int i = 5; i >= 0; i--)
      f.push_back(sa[8*i+:8]);
    f = {f, 8'h88, 8'h08, 8'h00, 8'h01, tm[15:8], tm[7:0]};
    while (f.size() < 60)
      f.push_back(8'h00);
  endtask

  task automatic report_and_stop;
    if (mismatches == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog
  initial
  begin
    #(50 * 20000);
    mismatches++;
    report_and_stop();
  end

  // main sequence
  initial
  begin
    {psel, penable, pwrite, promisc, addr_filter_pass, presetn} = 6'h0;
    paddr = '0;
    pwdata = '0;
    mismatches = 0;
    cmp_count = 0;
    hold_cnt = 0;
    rng = 32'hFB91;
    repeat (10) @(posedge pclk);
    rng = nxt(rng);
    presetn <= 1'b1;
    station_addr <= {rng[15:0], rng};
    apb(1'b0, mpfc_pkg::FLOW_ADDR, 32'h0);
    chk(rd, 32'h0);
    chk(er, 1'b0);
    apb(1'b0, 10'h3FC, 32'h0);
    chk(er, 1'b1);
    rng = nxt(rng);
    fl = {rng[15:0], 16'h0002};
    wr_flow(fl);
    apb(1'b0, mpfc_pkg::FLOW_ADDR, 32'h0);
    chk(rd, fl);
    chk(tx_valid, 1'b0);
    apb(1'b1, mpfc_pkg::AFC_ADDR, 32'h15);
    repeat (5) @(posedge pclk);
    chk(tx_valid, 1'b0);
    station.got.delete();
    apb(1'b1, mpfc_pkg::AFC_ADDR, 32'h1D);
    apb(1'b0, mpfc_pkg::FLOW_ADDR, 32'h0);
    chk(rd[0], 1'b1);
    while (station.got.size() < 60)
      @(posedge pclk);
    apb(1'b0, mpfc_pkg::FLOW_ADDR, 32'h0);
    chk(rd[0], 1'b0);
    chk(station.last_at, 60);
    build(station_addr, fl[31:16]);
    for (int i = 0; i < 60; i++)
      chk(station.got[i], f[i]);
    // half duplex back pressure, gated by enable and transmitter
    apb(1'b1, mpfc_pkg::AFC_ADDR, 32'h0);
    wr_flow(32'h0);
    apb(1'b1, mpfc_pkg::AFC_ADDR, 32'h1A);
    repeat (2) @(posedge pclk);
    chk(backpressure, 1'b0);
    apb(1'b1, mpfc_pkg::AFC_ADDR, 32'h0);
    wr_flow(32'h2);
    apb(1'b1, mpfc_pkg::AFC_ADDR, 32'h1A);
    apb(1'b0, mpfc_pkg::FLOW_ADDR, 32'h0);
    chk({backpressure, rd[0]}, 2'h3);
    apb(1'b1, mpfc_pkg::AFC_ADDR, 32'h12);
    repeat (2) @(posedge pclk);
    chk(backpressure, 1'b0);
    // received pause frames across forward, promiscuous, speed, crc, enable
    for (int i = 0; i < 6; i++)
    begin
      {fwd, prm, spd, ok, en} = {i == 1, i == 2, i != 3, i != 4, i != 5};
      t = (i == 3) ? 16'h1 : 16'h2;
      q = spd ? int'(mpfc_pkg::QCYC_100) : int'(mpfc_pkg::QCYC_10);
      e = (en && ok) ? int'(t) * q : 0;
      rng = nxt(rng);
      wr_flow({t, 13'h0, fwd, en, 1'b0});
      apb(1'b1, mpfc_pkg::AFC_ADDR, {27'h0, spd, 4'hC});
      promisc <= prm;
      addr_filter_pass <= rng[3];
      hold_cnt = 0;
      stat_q.delete();
      build({rng[15:0], rng}, t);
      station.send(f, ok);
      repeat (e + 20) @(posedge pclk);
      chk((e == 0) ? (hold_cnt == 0) : (hold_cnt >= e && hold_cnt <= e + 1), 1'b1);
      chk(stat_q.size(), 1);
      chk(stat_q[0].is_pause, en && ok);
      chk(stat_q[0].filter_pass, (en && ok) ? (fwd || prm) : rng[3]);
    end
    report_and_stop();
  end
endmodule

// *** tb/mpfc_station.sv ***
`timescale 1ns/100ps
// ==========================================================
// remote station: sinks pause frames, sends frames
// ==========================================================
module mpfc_station (
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // pause frames from the block
  input  wire logic                    tx_valid,
  input  wire logic [7:0]              tx_data,
  input  wire logic                    tx_last,
  output logic                         tx_ready,
  // frames towards the block
  output mpfc_pkg::mpfc_rx_beat_t      rx_in
);
  logic [7:0] got[$];
  logic [1:0] stall_q;
  int         last_at;

  initial rx_in = '0;

  // take bytes, stalling one cycle in three
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      stall_q  <= 2'h0;
      tx_ready <= 1'b0;
    end
    else
    begin
      stall_q  <= (stall_q == 2'h2) ? 2'h0 : stall_q + 2'h1;
      tx_ready <= (stall_q != 2'h0);
      if (tx_valid && tx_ready)
      begin
        got.push_back(tx_data);
        if (tx_last)
          last_at <= got.size();
      end
    end

  // one beat per cycle, crc flag on last beat; idle data inverted
  task automatic send(input logic [7:0] f[$], input logic ok);
    for (int i = 0; i < f.size(); i++)
    begin
      @(posedge pclk);
      rx_in <= {1'b1, i == 0, i == f.size() - 1, ok && (i == f.size() - 1), f[i]};
    end
    @(posedge pclk);
    rx_in <= {4'h0, ~f[f.size() - 1]};
  endtask
endmodule
